/* File: mac_error_frame_statistics.sv */
// Carrier loss, excess collision, overrun loss and good receive frame counters
`timescale 1ns/100ps
module mac_error_frame_statistics import mac_stat_pkg::*; (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Control from the MAC control register
  input  wire logic        i_counter_gather_en,
  // Transmit events
  input  wire logic        i_tx_start,
  input  wire logic        i_tx_sfd_done,
  input  wire logic        i_crs,
  input  wire logic        i_tx_collision,
  input  wire logic        i_tx_end,
  input  wire logic        i_tx_abort_excess_coll,
  // Receive events
  input  wire logic        i_rx_start,
  input  wire logic        i_rx_full_at_start,
  input  wire logic        i_rx_overrun,
  input  wire logic        i_rx_end,
  input  wire logic        i_rx_addr_match,
  input  wire logic        i_rx_too_long,
  input  wire logic        i_rx_fcs_err,
  input  wire logic        i_rx_len_err,
  input  wire logic        i_rx_align_err,
  // Register read port
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  output logic [15:0]      o_reg_rd_data,
  output logic             o_reg_rd_valid,
  // Statistics-update flag request
  output logic             o_counter_threshold_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit frame tracking for carrier loss

  tx_phase_t tx_phase;
  tx_phase_t next_tx_phase;
  logic      carrier_lost;
  logic      next_carrier_lost;
  logic      collided;
  logic      next_collided;
  logic      carrier_evt;

  always_comb begin
    next_tx_phase     = tx_phase;
    next_carrier_lost = carrier_lost;
    next_collided     = collided;
    carrier_evt       = 1'b0;
    unique case (tx_phase)
      TX_IDLE: begin
        if (i_tx_start) begin
          next_tx_phase     = TX_PREAMBLE;
          next_carrier_lost = 1'b0;
          next_collided     = i_tx_collision;
        end
      end
      TX_PREAMBLE: begin
        // Carrier sense is not looked at until the delimiter is out
        next_collided = collided | i_tx_collision;
        if (i_tx_end) begin
          next_tx_phase = TX_IDLE;
        end else if (i_tx_sfd_done) begin
          next_tx_phase = TX_BODY;
        end
      end
      TX_BODY: begin
        next_carrier_lost = carrier_lost | ~i_crs;
        next_collided     = collided | i_tx_collision;
        if (i_tx_end) begin
          next_tx_phase = TX_IDLE;
          // Once per frame, and never for a frame that collided
          carrier_evt   = next_carrier_lost & ~next_collided;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_phase     <= TX_IDLE;
      carrier_lost <= 1'b0;
      collided     <= 1'b0;
    end else begin
      tx_phase     <= next_tx_phase;
      carrier_lost <= next_carrier_lost;
      collided     <= next_collided;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive frame tracking

  rx_phase_t rx_phase;
  rx_phase_t next_rx_phase;
  logic      rx_dropped;
  logic      next_rx_dropped;
  logic      rx_ovr_seen;
  logic      next_rx_ovr_seen;
  logic      ovr_now;
  logic      rx_err_now;
  logic      overrun_evt;
  logic      good_evt;

  always_comb begin
    next_rx_phase    = rx_phase;
    next_rx_dropped  = rx_dropped;
    next_rx_ovr_seen = rx_ovr_seen;
    ovr_now          = rx_ovr_seen | i_rx_overrun;
    rx_err_now       = i_rx_too_long | i_rx_fcs_err | i_rx_len_err | i_rx_align_err;
    overrun_evt      = 1'b0;
    good_evt         = 1'b0;
    unique case (rx_phase)
      RX_IDLE: begin
        if (i_rx_start) begin
          next_rx_phase    = RX_FRAME;
          // A frame refused outright never reaches the host
          next_rx_dropped  = i_rx_full_at_start;
          next_rx_ovr_seen = i_rx_overrun;
        end
      end
      RX_FRAME: begin
        next_rx_ovr_seen = ovr_now;
        if (i_rx_end) begin
          next_rx_phase    = RX_IDLE;
          next_rx_ovr_seen = 1'b0;
          overrun_evt      = i_rx_addr_match & ovr_now & ~rx_dropped;
          good_evt         = ~rx_err_now & ~ovr_now & ~rx_dropped;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_phase    <= RX_IDLE;
      rx_dropped  <= 1'b0;
      rx_ovr_seen <= 1'b0;
    end else begin
      rx_phase    <= next_rx_phase;
      rx_dropped  <= next_rx_dropped;
      rx_ovr_seen <= next_rx_ovr_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  logic              inc_carrier;
  logic              inc_xs;
  logic              inc_overrun;
  logic              inc_good;
  logic              rd_carrier;
  logic              rd_xs;
  logic              rd_overrun;
  logic              rd_good;
  logic [BYTE_W-1:0] cnt_carrier;
  logic [BYTE_W-1:0] cnt_xs;
  logic [BYTE_W-1:0] cnt_overrun;
  logic [GOOD_W-1:0] cnt_good;
  logic              hit_carrier;
  logic              hit_xs;
  logic              hit_overrun;
  logic              hit_good;

  // Gathering off freezes all four counters, reads still clear them
  assign inc_carrier = carrier_evt & i_counter_gather_en;
  assign inc_xs      = i_tx_abort_excess_coll & i_counter_gather_en;
  assign inc_overrun = overrun_evt & i_counter_gather_en;
  assign inc_good    = good_evt & i_counter_gather_en;

  assign rd_carrier = i_reg_rd && (i_reg_addr == OFS_CARRIER);
  assign rd_xs      = i_reg_rd && (i_reg_addr == OFS_XS_COLL);
  assign rd_overrun = i_reg_rd && (i_reg_addr == OFS_RX_OVERRUN);
  assign rd_good    = i_reg_rd && (i_reg_addr == OFS_GOOD_RX);

  stat_counter #(.W(BYTE_W), .RST_VAL(RST_BYTE)) u_carrier (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_inc     (inc_carrier),
    .i_clr     (rd_carrier),
    .o_count   (cnt_carrier),
    .o_hit     (hit_carrier)
  );

  stat_counter #(.W(BYTE_W), .RST_VAL(RST_BYTE)) u_xs_coll (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_inc     (inc_xs),
    .i_clr     (rd_xs),
    .o_count   (cnt_xs),
    .o_hit     (hit_xs)
  );

  stat_counter #(.W(BYTE_W), .RST_VAL(RST_BYTE)) u_rx_overrun (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_inc     (inc_overrun),
    .i_clr     (rd_overrun),
    .o_count   (cnt_overrun),
    .o_hit     (hit_overrun)
  );

  stat_counter #(.W(GOOD_W), .RST_VAL(RST_GOOD)) u_good_rx (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_inc     (inc_good),
    .i_clr     (rd_good),
    .o_count   (cnt_good),
    .o_hit     (hit_good)
  );

  // Pulse lands in the cycle the count shows the threshold
  assign o_counter_threshold_irq = hit_carrier | hit_xs | hit_overrun | hit_good;

  ////////////////////////////////////////////////////////////////////////////
  // Register read data

  logic [15:0] rd_data;
  logic [15:0] next_rd_data;
  logic        rd_valid;

  always_comb begin
    next_rd_data = rd_data;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        // Upper nibble is reserved and reads as zero
        OFS_CARRIER:    next_rd_data = {12'h000, cnt_carrier[CARRIER_FLD_MSB:0]};
        OFS_XS_COLL:    next_rd_data = {8'h00, cnt_xs};
        OFS_RX_OVERRUN: next_rd_data = {8'h00, cnt_overrun};
        OFS_GOOD_RX:    next_rd_data = cnt_good;
        default:        next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= i_reg_rd;
    end
  end

  assign o_reg_rd_data  = rd_data;
  assign o_reg_rd_valid = rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  AST_CARRIER_COUNT: assert property (
    (carrier_evt && i_counter_gather_en && !rd_carrier)
      |=> (cnt_carrier == $past(cnt_carrier) + 8'h01))
    else $error("carrier loss frame not counted");

  AST_PREAMBLE_IGNORE: assert property (
    (tx_phase == TX_PREAMBLE && !carrier_lost) |=> !carrier_lost)
    else $error("carrier sense observed during preamble");

  AST_CARRIER_WRAP: assert property (
    (cnt_carrier == 8'hff && inc_carrier && !rd_carrier) |=> (cnt_carrier == 8'h00))
    else $error("carrier loss counter did not wrap");

  AST_CARRIER_FIELD: assert property (
    rd_carrier |=> (o_reg_rd_valid && o_reg_rd_data[15:4] == 12'h000
                    && o_reg_rd_data[3:0] == $past(cnt_carrier[3:0])))
    else $error("carrier loss read field wrong");

  AST_THRESHOLD_FLAG: assert property (
    (inc_xs && !rd_xs && cnt_xs == 8'hbf)
      |=> (o_counter_threshold_irq && cnt_xs == 8'hc0))
    else $error("threshold flag missing");

  AST_FLAG_CAUSE: assert property (
    o_counter_threshold_irq |-> (cnt_carrier == 8'hc0 || cnt_xs == 8'hc0
                                 || cnt_overrun == 8'hc0 || cnt_good == 16'h00c0))
    else $error("threshold flag without a counter at threshold");

  AST_GATHER_OFF: assert property (
    (!i_counter_gather_en && !i_reg_rd)
      |=> ($stable(cnt_carrier) && $stable(cnt_xs) && $stable(cnt_overrun)
           && $stable(cnt_good)))
    else $error("counter moved while gathering disabled");

  AST_READ_CLEAR: assert property (
    (rd_overrun && !inc_overrun)
      |=> (cnt_overrun == 8'h00 && o_reg_rd_data == {8'h00, $past(cnt_overrun)}))
    else $error("read did not return and clear");

  AST_XS_COUNT: assert property (
    (i_tx_abort_excess_coll && i_counter_gather_en && !rd_xs)
      |=> (cnt_xs == $past(cnt_xs) + 8'h01))
    else $error("excess collision abort not counted");

  AST_OVERRUN_COUNT: assert property (
    (rx_phase == RX_FRAME && i_rx_end && i_rx_overrun && i_rx_addr_match
     && !rx_dropped && i_counter_gather_en && !rd_overrun)
      |=> (cnt_overrun == $past(cnt_overrun) + 8'h01))
    else $error("overrun loss not counted");

  AST_OVERRUN_SKIP_FULL: assert property (
    (i_rx_end && rx_dropped && !rd_overrun) |=> $stable(cnt_overrun))
    else $error("frame dropped at start was counted");

  AST_GOOD_EXCLUDE: assert property (
    (i_rx_end && (i_rx_too_long || i_rx_fcs_err || i_rx_len_err || i_rx_align_err)
     && !rd_good) |=> $stable(cnt_good))
    else $error("errored frame counted as good");

  AST_GOOD_WRAP: assert property (
    (cnt_good == 16'hffff && inc_good && !rd_good) |=> (cnt_good == 16'h0000))
    else $error("good receive counter did not wrap");

  AST_READ_RACE: assert property (
    (rd_good && inc_good)
      |=> (cnt_good == 16'h0001 && o_reg_rd_data == $past(cnt_good)))
    else $error("event lost during read");

  COV_CARRIER_LOSS: cover property (inc_carrier);
  COV_THRESHOLD:    cover property (o_counter_threshold_irq);
  COV_READ_RACE:    cover property (rd_xs && inc_xs);
  COV_OVERRUN:      cover property (rd_overrun && cnt_overrun != 8'h00);

endmodule

/* File: mac_error_frame_statistics_tb.sv */
// Self-checking testbench for the MAC error and frame statistics counters
`timescale 1ns/100ps
module mac_error_frame_statistics_tb;
  import mac_stat_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic        gen = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] rdata;
  logic        rvalid;
  logic        irq;
  logic [15:0] d;
  wire logic   ts, sfd, crs, col, te, xab, rs, rfull, rovr, re, rmatch;
  wire logic [3:0] rerr;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          irqs = 0;
  int          i0;

  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (irq === 1'b1) irqs <= irqs + 1;

  mac_event_model m (.i_clk_sys(i_clk_sys), .o_tx_start(ts), .o_tx_sfd_done(sfd),
    .o_crs(crs), .o_tx_collision(col), .o_tx_end(te), .o_tx_abort_excess_coll(xab),
    .o_rx_start(rs), .o_rx_full_at_start(rfull), .o_rx_overrun(rovr), .o_rx_end(re),
    .o_rx_addr_match(rmatch), .o_rx_err(rerr));

  mac_error_frame_statistics u_mac_error_frame_statistics (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_counter_gather_en(gen), .i_tx_start(ts), .i_tx_sfd_done(sfd),
    .i_crs(crs), .i_tx_collision(col), .i_tx_end(te), .i_tx_abort_excess_coll(xab),
    .i_rx_start(rs), .i_rx_full_at_start(rfull), .i_rx_overrun(rovr), .i_rx_end(re),
    .i_rx_addr_match(rmatch), .i_rx_too_long(rerr[3]), .i_rx_fcs_err(rerr[2]),
    .i_rx_len_err(rerr[1]), .i_rx_align_err(rerr[0]), .i_reg_rd(rd), .i_reg_addr(addr),
    .o_reg_rd_data(rdata), .o_reg_rd_valid(rvalid), .o_counter_threshold_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Valid is registered, so it is already up at the falling edge after the strobe
  task automatic rdreg(input logic [7:0] a, output logic [15:0] v);
    @(negedge i_clk_sys); rd = 1'b1; addr = a;
    @(negedge i_clk_sys); rd = 1'b0;
    chk("rd_valid", {15'h0000, rvalid}, 16'h0001);
    v = rdata;
  endtask

  task automatic expect_reg(input string n, input logic [7:0] a, input logic [15:0] e);
    rdreg(a, d);
    chk(n, d, e);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    gen = 1'b1;
    expect_reg("good", OFS_GOOD_RX, RST_GOOD);
    expect_reg("carrier", OFS_CARRIER, 16'h0000);
    expect_reg("overrun", OFS_RX_OVERRUN, 16'h0000);
    expect_reg("xs_coll", OFS_XS_COLL, 16'h0000);
    $display("test reset values done");
    m.tx(1'b0, 1'b1, 1'b0);
    m.tx(1'b0, 1'b1, 1'b1);
    m.tx(1'b1, 1'b0, 1'b0);
    m.tx(1'b0, 1'b0, 1'b0);
    expect_reg("carrier", OFS_CARRIER, 16'h0001);
    expect_reg("carrier", OFS_CARRIER, 16'h0000);
    // 257 frames: the 8-bit count wraps once, so the field shows one, not 0xf
    repeat (257) m.tx(1'b0, 1'b1, 1'b0);
    expect_reg("carrier", OFS_CARRIER, 16'h0001);
    $display("test carrier loss done");
    gen = 1'b0;
    m.abort();
    m.tx(1'b0, 1'b1, 1'b0);
    gen = 1'b1;
    expect_reg("xs_coll", OFS_XS_COLL, 16'h0000);
    expect_reg("carrier", OFS_CARRIER, 16'h0000);
    i0 = irqs;
    repeat (192) m.abort();
    @(negedge i_clk_sys);
    chk("irq", 16'(irqs - i0), 16'h0001);
    expect_reg("xs_coll", OFS_XS_COLL, 16'h00c0);
    repeat (256) m.abort();
    expect_reg("xs_coll", OFS_XS_COLL, 16'h0000);
    chk("irq", 16'(irqs - i0), 16'h0002);
    fork
      rdreg(OFS_XS_COLL, d);
      m.abort();
    join
    chk("xs_coll", d, 16'h0000);
    expect_reg("xs_coll", OFS_XS_COLL, 16'h0001);
    $display("test excess collision done");
    m.rx(1'b0, 1'b1, 1'b1, 4'h0);
    m.rx(1'b1, 1'b1, 1'b1, 4'h0);
    m.rx(1'b0, 1'b1, 1'b0, 4'h0);
    m.rx(1'b0, 1'b0, 1'b0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      m.rx(1'b0, 1'b0, 1'b1, 4'(1 << i));
    end
    expect_reg("overrun", OFS_RX_OVERRUN, 16'h0001);
    expect_reg("good", OFS_GOOD_RX, 16'h0001);
    i0 = irqs;
    repeat (192) m.rx(1'b0, 1'b0, 1'b1, 4'h0);
    @(negedge i_clk_sys);
    chk("irq", 16'(irqs - i0), 16'h0001);
    expect_reg("good", OFS_GOOD_RX, 16'h00c0);
    expect_reg("unmapped", 8'h73, 16'h0000);
    $display("test receive done");
    m.rx(1'b0, 1'b0, 1'b1, 4'h0);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    expect_reg("good", OFS_GOOD_RX, RST_GOOD);
    $display("test mid-run reset done");
    end_of_test();
  end

  // Whole run needs about 3000 cycles
  initial begin
    repeat (8000) @(posedge i_clk_sys);
    mismatches++;
    end_of_test();
  end
endmodule

/* File: mac_event_model.sv */
// Behavioural model of the MAC transmit and receive event logic
`timescale 1ns/100ps
module mac_event_model (
  // Clock
  input  wire logic i_clk_sys,
  // Transmit events
  output logic      o_tx_start = 1'b0,
  output logic      o_tx_sfd_done = 1'b0,
  output logic      o_crs = 1'b0,
  output logic      o_tx_collision = 1'b0,
  output logic      o_tx_end = 1'b0,
  output logic      o_tx_abort_excess_coll = 1'b0,
  // Receive events
  output logic      o_rx_start = 1'b0,
  output logic      o_rx_full_at_start = 1'b0,
  output logic      o_rx_overrun = 1'b0,
  output logic      o_rx_end = 1'b0,
  output logic      o_rx_addr_match = 1'b0,
  output logic [3:0] o_rx_err = 4'h0
);
  ////////////////////////////////////////////////////////////////////////////
  // Carrier is low between frames, so idle must never count
  task automatic tx(input logic pre_drop, input logic drop, input logic coll);
    @(negedge i_clk_sys); o_tx_start = 1'b1; o_crs = ~pre_drop;
    // Carrier may also drop in the preamble cycle, which must be ignored
    @(negedge i_clk_sys); o_tx_start = 1'b0; o_tx_sfd_done = 1'b1; o_crs = ~pre_drop;
    @(negedge i_clk_sys); o_tx_sfd_done = 1'b0; o_crs = ~drop; o_tx_collision = coll;
    @(negedge i_clk_sys); o_tx_end = 1'b1;
    @(negedge i_clk_sys); o_tx_end = 1'b0; o_crs = 1'b0; o_tx_collision = 1'b0;
  endtask

  task automatic abort();
    @(negedge i_clk_sys); o_tx_abort_excess_coll = 1'b1;
    @(negedge i_clk_sys); o_tx_abort_excess_coll = 1'b0;
  endtask

  // Error order: too long, FCS, length, alignment
  task automatic rx(input logic full, input logic ovr, input logic match,
                    input logic [3:0] err);
    @(negedge i_clk_sys); o_rx_start = 1'b1; o_rx_full_at_start = full;
    @(negedge i_clk_sys); o_rx_start = 1'b0; o_rx_full_at_start = 1'b0; o_rx_overrun = ovr;
    @(negedge i_clk_sys); o_rx_overrun = 1'b0; o_rx_end = 1'b1;
    o_rx_addr_match = match; o_rx_err = err;
    @(negedge i_clk_sys); o_rx_end = 1'b0; o_rx_addr_match = 1'b0; o_rx_err = 4'h0;
  endtask
endmodule

/* File: mac_stat_pkg.sv */
// Shared constants and types for the MAC error and frame statistics counters
package mac_stat_pkg;

  // Register byte offsets inside the I/O window
  localparam logic [7:0]  OFS_GOOD_RX     = 8'h72;
  localparam logic [7:0]  OFS_CARRIER     = 8'h74;
  localparam logic [7:0]  OFS_RX_OVERRUN  = 8'h79;
  localparam logic [7:0]  OFS_XS_COLL     = 8'h7b;

  // Widths and field positions
  localparam int          GOOD_W          = 16;
  localparam int          BYTE_W          = 8;
  localparam int          CARRIER_FLD_MSB = 3;
  localparam int          CARRIER_FLD_W   = 4;

  // Reset values
  localparam logic [15:0] RST_GOOD        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;

  // Count at which the update flag is raised
  localparam logic [15:0] STAT_THRESHOLD  = 16'h00c0;

  typedef enum {TX_IDLE, TX_PREAMBLE, TX_BODY} tx_phase_t;
  typedef enum {RX_IDLE, RX_FRAME} rx_phase_t;

endpackage

/* File: stat_counter.sv */
// One clear-on-read statistics counter with threshold detection
`timescale 1ns/100ps
module stat_counter import mac_stat_pkg::*; #(
  parameter int         W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // Event and host read
  input  wire logic         i_inc,
  input  wire logic         i_clr,
  // State
  output logic [W-1:0]      o_count,
  output logic              o_hit
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         hit;
  logic         next_hit;

  always_comb begin
    next_count = count;
    next_hit   = 1'b0;
    if (i_clr) begin
      // An event in the read cycle survives as a count of one
      next_count = i_inc ? W'(1) : '0;
    end else if (i_inc) begin
      next_count = count + W'(1);
      next_hit   = ((count + W'(1)) == STAT_THRESHOLD[W-1:0]);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      count <= RST_VAL;
      hit   <= 1'b0;
    end else begin
      count <= next_count;
      hit   <= next_hit;
    end
  end

  assign o_count = count;
  assign o_hit   = hit;

endmodule
